// [rtl/rip_resolver.sv]
// Purpose: reset and interrupt priority resolver with mode register
// Assumes: mask bits and trap strobes come from the cpu core on this clock
// Notes: pins are filtered by three flops; the answer lags its cause one cycle
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "rip_defs.svh"

module rip_resolver import rip_pkg::*; #(
	parameter int ADDR_W = 16
) (
	input wire logic clock, // 100 MHz bus clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic mode_pin_b, // mode pin b, asynchronous
	input wire logic mode_pin_a, // mode pin a, asynchronous
	input wire logic irq_pin_n, // external interrupt pin, asynchronous
	input wire logic nonmaskable_pin_interrupt_n, // x pin, asynchronous
	input wire logic global_mask, // cpu i mask bit
	input wire logic x_mask, // cpu x mask bit
	input wire logic por_req, // power-on or reset pin request
	input wire logic clock_fail, // clock monitor detects slow clock
	input wire logic clock_monitor_enable, // clock monitor armed
	input wire logic watchdog_timeout, // watchdog_system time-out
	input wire logic watchdog_disable, // watchdog_system off
	input wire logic illegal_opcode, // illegal opcode detected
	input wire logic software_trap, // trap instruction executing
	input wire logic vector_ack, // cpu fetched the presented vector
	input wire logic [12:0] periph_flag, // rti to spi flags, default order
	input wire logic [12:0] periph_enable, // local enables of those flags
	input wire logic rx_full_set, // serial receiver loaded a character
	input wire logic rx_overrun, // serial overrun flag
	input wire logic tx_empty, // serial transmit empty flag
	input wire logic tx_done, // serial transmit complete flag
	input wire logic idle_line, // serial idle line flag
	input wire logic receive_irq_enable, // receive and overrun enable
	input wire logic transmit_empty_irq_enable, // transmit empty enable
	input wire logic transmit_done_irq_enable, // transmit complete enable
	input wire logic idle_line_irq_enable, // idle line enable
	input wire logic serial_status_read, // software read serial status
	input wire logic serial_data_read, // software read serial data
	input wire logic int_read_strobe, // internal read in progress
	input wire logic [7:0] int_read_data, // data of internal read
	output logic int_request, // some source pending
	output logic [15:0] vector_addr, // vector of the winner
	output rip_src_e int_source, // class of the winner
	output logic [3:0] maskable_index, // default rank of maskable winner
	output logic receive_full_flag, // serial receive full flag
	output logic [7:0] ext_data_out, // visible internal read data
	output logic ext_data_oe_n // low while driving external bus
);
	localparam int NM = `RIP_NUM_MASKABLE;
	rip_mode_s highest_priority_and_mode;
	logic irq_edge_mode;
	logic irv_written;
	logic [1:0] cap_cnt;
	logic cap_done;
	logic [2:0] mode_pin_b_s, mode_pin_a_s, irq_s, xpin_s;
	logic irq_low, xpin_low, irq_low_d, irq_edge_latch;
	logic rx_armed;
	logic aw_held, w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	logic [NM-1:0] pend, masked;
	logic sci_req, irq_req;
	logic [3:0] prom_idx, win_idx;
	logic nm_any;
	rip_src_e next_src;
	logic [15:0] next_vec;

	// pin filters: a change counts once stages two and three agree
	always_ff @(posedge clock) begin
		mode_pin_b_s <= {mode_pin_b_s[1:0], mode_pin_b};
		mode_pin_a_s <= {mode_pin_a_s[1:0], mode_pin_a};
		irq_s <= {irq_s[1:0], irq_pin_n};
		xpin_s <= {xpin_s[1:0], nonmaskable_pin_interrupt_n};
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			irq_low <= 1'b0;
			xpin_low <= 1'b0;
		end else begin
			if (irq_s[1] == irq_s[2])
				irq_low <= !irq_s[2];
			if (xpin_s[1] == xpin_s[2])
				xpin_low <= !xpin_s[2];
		end
	end

	// mode pins are sampled once the filter has filled after release
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cap_cnt <= 2'h0;
			cap_done <= 1'b0;
		end else if (!cap_done) begin
			if (cap_cnt != `RIP_CAP_WAIT)
				cap_cnt <= cap_cnt + 2'h1;
			else if (mode_pin_b_s[1] == mode_pin_b_s[2] && mode_pin_a_s[1] == mode_pin_a_s[2])
				cap_done <= 1'b1;
		end
	end

	wire cap_now = !cap_done && cap_cnt == `RIP_CAP_WAIT
		&& mode_pin_b_s[1] == mode_pin_b_s[2] && mode_pin_a_s[1] == mode_pin_a_s[2];

	// register bus: address and data taken in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	wire wr_highest_priority_and_mode = aw_addr == ADDR_W'(`RIP_ADDR_HIGHEST_PRIORITY_AND_MODE);
	wire wr_ctrl = aw_addr == ADDR_W'(`RIP_ADDR_CTRL);
	wire wr_lane0 = wr_fire && w_strb[0];

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RIP_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_highest_priority_and_mode || wr_ctrl || aw_addr == ADDR_W'(`RIP_ADDR_STAT))
					? `RIP_RESP_OKAY : `RIP_RESP_SLVERR;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// mode and priority register
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			highest_priority_and_mode <= `RIP_HIGHEST_PRIORITY_AND_MODE_RST_SINGLE;
			irv_written <= 1'b0;
		end else if (cap_now) begin
			unique case ({mode_pin_b_s[2], mode_pin_a_s[2]})
			2'b00: highest_priority_and_mode <= `RIP_HIGHEST_PRIORITY_AND_MODE_RST_BOOT;
			2'b01: highest_priority_and_mode <= `RIP_HIGHEST_PRIORITY_AND_MODE_RST_TEST;
			2'b10: highest_priority_and_mode <= `RIP_HIGHEST_PRIORITY_AND_MODE_RST_SINGLE;
			2'b11: highest_priority_and_mode <= `RIP_HIGHEST_PRIORITY_AND_MODE_RST_EXPANDED;
			endcase
		end else if (wr_lane0 && wr_highest_priority_and_mode) begin
			if (global_mask)
				highest_priority_and_mode.psel <= w_data[3:0];
			if (highest_priority_and_mode.special_mode_bit) begin
				highest_priority_and_mode.boot_rom_select <= w_data[7];
				highest_priority_and_mode.mode_a_bit <= w_data[5];
				if (!w_data[6])
					highest_priority_and_mode.special_mode_bit <= 1'b0;
				highest_priority_and_mode.internal_read_visibility <= w_data[4];
			end else if (!irv_written) begin
				highest_priority_and_mode.internal_read_visibility <= w_data[4];
				irv_written <= 1'b1;
			end
		end
	end

	// irq pin sensitivity, low level out of reset
	always_ff @(posedge clock) begin
		if (!rst_n)
			irq_edge_mode <= `RIP_CTRL_RST;
		else if (wr_lane0 && wr_ctrl)
			irq_edge_mode <= w_data[0];
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			irq_low_d <= 1'b0;
			irq_edge_latch <= 1'b0;
		end else begin
			irq_low_d <= irq_low;
			if (irq_low && !irq_low_d)
				irq_edge_latch <= 1'b1;
			else if (vector_ack && int_source == RIP_SRC_MASKABLE
				&& maskable_index == `RIP_IDX_IRQ)
				irq_edge_latch <= 1'b0;
		end
	end

	// receive full: a status read while set arms, a later data read clears
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			receive_full_flag <= 1'b0;
			rx_armed <= 1'b0;
		end else if (rx_full_set) begin
			receive_full_flag <= 1'b1; // set wins over the clear sequence
			rx_armed <= 1'b0;
		end else if (serial_data_read && rx_armed) begin
			receive_full_flag <= 1'b0;
			rx_armed <= 1'b0;
		end else if (serial_status_read && receive_full_flag)
			rx_armed <= 1'b1;
	end

	// register reads
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `RIP_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `RIP_RESP_OKAY;
			if (s_axi_araddr == ADDR_W'(`RIP_ADDR_HIGHEST_PRIORITY_AND_MODE))
				s_axi_rdata <= {24'h0, highest_priority_and_mode};
			else if (s_axi_araddr == ADDR_W'(`RIP_ADDR_CTRL))
				s_axi_rdata <= {31'h0, irq_edge_mode};
			else if (s_axi_araddr == ADDR_W'(`RIP_ADDR_STAT))
				s_axi_rdata <= {16'h0, receive_full_flag, masked};
			else begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= `RIP_RESP_SLVERR;
			end
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// maskable requests in default order; levels except irq in edge mode, so they drop with the flag
	assign sci_req = (receive_full_flag && receive_irq_enable)
		|| (rx_overrun && receive_irq_enable)
		|| (tx_empty && transmit_empty_irq_enable)
		|| (tx_done && transmit_done_irq_enable)
		|| (idle_line && idle_line_irq_enable);
	assign irq_req = irq_edge_mode ? irq_edge_latch : irq_low;
	assign pend = {sci_req, periph_flag & periph_enable, irq_req};
	assign masked = global_mask ? '0 : pend;

	always_comb begin
		unique case (highest_priority_and_mode.psel)
		4'h0: prom_idx = 4'ha;
		4'h1: prom_idx = 4'hb;
		4'h2: prom_idx = 4'hc;
		4'h3: prom_idx = 4'hd;
		4'h4: prom_idx = `RIP_IDX_SCI;
		`RIP_PSEL_RESERVED: prom_idx = `RIP_IDX_IRQ;
		4'h6: prom_idx = `RIP_IDX_IRQ;
		default: prom_idx = highest_priority_and_mode.psel - 4'h6;
		endcase
	end

	// first pending by default rank, promoted one taking precedence
	always_comb begin
		win_idx = 4'h0;
		for (int i = NM - 1; i >= 0; i--) begin
			if (masked[i])
				win_idx = 4'(i);
		end
		if (masked[prom_idx])
			win_idx = prom_idx;
	end

	wire clkmon_req = clock_fail && clock_monitor_enable;
	wire wd_req = watchdog_timeout && !watchdog_disable;
	wire xpin_req = xpin_low && !x_mask;
	assign nm_any = por_req || clkmon_req || wd_req || xpin_req
		|| illegal_opcode || software_trap;

	always_comb begin
		next_src = RIP_SRC_NONE;
		next_vec = 16'h0;
		if (por_req) begin
			next_src = RIP_SRC_RESET;
			next_vec = `RIP_VEC_RESET;
		end else if (clkmon_req) begin
			next_src = RIP_SRC_CLKMON;
			next_vec = `RIP_VEC_CLKMON;
		end else if (wd_req) begin
			next_src = RIP_SRC_WATCHDOG;
			next_vec = `RIP_VEC_WATCHDOG;
		end else if (xpin_req) begin
			next_src = RIP_SRC_XPIN;
			next_vec = `RIP_VEC_XPIN;
		end else if (illegal_opcode) begin
			next_src = RIP_SRC_ILLEGAL;
			next_vec = `RIP_VEC_ILLEGAL;
		end else if (software_trap) begin
			next_src = RIP_SRC_SWTRAP;
			next_vec = `RIP_VEC_SWTRAP;
		end else if (|masked) begin
			next_src = RIP_SRC_MASKABLE;
			next_vec = `RIP_VEC_IRQ - {11'h0, win_idx, 1'b0};
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			int_request <= 1'b0;
			int_source <= RIP_SRC_NONE;
			vector_addr <= 16'h0;
			maskable_index <= 4'h0;
		end else begin
			int_request <= next_src != RIP_SRC_NONE;
			int_source <= next_src;
			vector_addr <= next_vec;
			maskable_index <= win_idx;
		end
	end

	// internal read visibility: only in expanded modes, mode a set
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ext_data_out <= 8'h0;
			ext_data_oe_n <= 1'b1;
		end else if (int_read_strobe && highest_priority_and_mode.internal_read_visibility
			&& highest_priority_and_mode.mode_a_bit) begin
			ext_data_out <= int_read_data;
			ext_data_oe_n <= 1'b0;
		end else
			ext_data_oe_n <= 1'b1;
	end

	default clocking rip_cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_psel_write_gate: assert property (
		wr_fire && wr_highest_priority_and_mode && !global_mask && !cap_now |=> $stable(highest_priority_and_mode.psel))
		else $error("priority select changed while global mask clear");
	a_psel_write_take: assert property (
		wr_lane0 && wr_highest_priority_and_mode && global_mask && !cap_now |=> highest_priority_and_mode.psel == $past(w_data[3:0]))
		else $error("priority select write lost");
	a_promoted_wins: assert property (
		!nm_any && masked[prom_idx] |=> int_source == RIP_SRC_MASKABLE
			&& maskable_index == $past(prom_idx))
		else $error("promoted source did not win");
	a_vector_fixed: assert property (
		int_source == RIP_SRC_MASKABLE |-> vector_addr
			== `RIP_VEC_IRQ - {11'h0, maskable_index, 1'b0})
		else $error("vector moved with promotion");
	a_global_mask_blocks: assert property (
		global_mask |=> int_source != RIP_SRC_MASKABLE)
		else $error("maskable source passed global mask");
	a_reset_first: assert property (
		por_req |=> int_source == RIP_SRC_RESET && vector_addr == `RIP_VEC_RESET)
		else $error("reset request not highest");
	a_trap_unmasked: assert property (
		software_trap && !por_req && !clkmon_req && !wd_req && !xpin_req
			&& !illegal_opcode |=> int_source == RIP_SRC_SWTRAP)
		else $error("software trap not taken");
	a_special_clear_only: assert property (
		cap_done && !highest_priority_and_mode.special_mode_bit |=> !highest_priority_and_mode.special_mode_bit)
		else $error("special mode bit set by software");
	a_irv_single_write: assert property (
		cap_done && !highest_priority_and_mode.special_mode_bit && irv_written |=>
			$stable(highest_priority_and_mode.internal_read_visibility))
		else $error("visibility written twice in normal mode");
	a_rx_clear_seq: assert property (
		receive_full_flag && rx_armed && serial_data_read && !rx_full_set
			|=> !receive_full_flag)
		else $error("receive full not cleared by read sequence");
	a_overrun_request: assert property (
		rx_overrun && receive_irq_enable && !global_mask |=> int_request)
		else $error("serial overrun request lost");
endmodule

// [rtl/rip_defs.svh]
// Purpose: constants for the reset and interrupt priority resolver
// Assumes: 16-bit byte addresses on the register bus
// Notes: register offsets are byte addresses
`ifndef RIP_DEFS_SVH
`define RIP_DEFS_SVH
`define RIP_ADDR_HIGHEST_PRIORITY_AND_MODE 16'h103c
`define RIP_ADDR_CTRL 16'h1040
`define RIP_ADDR_STAT 16'h1044
`define RIP_HIGHEST_PRIORITY_AND_MODE_RST_SINGLE 8'h05
`define RIP_HIGHEST_PRIORITY_AND_MODE_RST_EXPANDED 8'h35
`define RIP_HIGHEST_PRIORITY_AND_MODE_RST_BOOT 8'hc5
`define RIP_HIGHEST_PRIORITY_AND_MODE_RST_TEST 8'h75
`define RIP_PSEL_RESERVED 4'h5
`define RIP_CTRL_RST 1'h0
`define RIP_NUM_MASKABLE 15
`define RIP_IDX_IRQ 4'h0
`define RIP_IDX_SCI 4'he
`define RIP_VEC_RESET 16'hfffe
`define RIP_VEC_CLKMON 16'hfffc
`define RIP_VEC_WATCHDOG 16'hfffa
`define RIP_VEC_ILLEGAL 16'hfff8
`define RIP_VEC_SWTRAP 16'hfff6
`define RIP_VEC_XPIN 16'hfff4
`define RIP_VEC_IRQ 16'hfff2
`define RIP_VEC_STEP 5'h02
`define RIP_CAP_WAIT 2'h3
`define RIP_RESP_OKAY 2'h0
`define RIP_RESP_SLVERR 2'h2
`endif

// [rtl/rip_pkg.sv]
// Purpose: types shared by the resolver
// Assumes: nothing beyond the defines header
// Notes: field order of the mode register matches its bit order
package rip_pkg;
	typedef struct packed {
		logic boot_rom_select;
		logic special_mode_bit;
		logic mode_a_bit;
		logic internal_read_visibility;
		logic [3:0] psel;
	} rip_mode_s;
	typedef enum logic [2:0] {
		RIP_SRC_NONE,
		RIP_SRC_RESET,
		RIP_SRC_CLKMON,
		RIP_SRC_WATCHDOG,
		RIP_SRC_XPIN,
		RIP_SRC_ILLEGAL,
		RIP_SRC_SWTRAP,
		RIP_SRC_MASKABLE
	} rip_src_e;
endpackage

// [dv/rip_cpu_model.sv]
// Purpose: cpu core stand-in that owns the mask bits and fetches vectors
// Assumes: same clock as the resolver; the bench asks for mask levels
// Notes: fetch comes a few cycles late, as if an instruction finished first
`timescale 1ns/1ps
module rip_cpu_model (
	input wire logic clock, // bus clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic int_request, // resolver has a winner
	input wire logic [15:0] vector_addr, // vector of the winner
	input wire logic want_i, // requested i mask level
	input wire logic want_x, // requested x mask level
	input wire logic ack_en, // fetch vectors while requested
	output logic global_mask, // i mask bit
	output logic x_mask, // x mask bit
	output logic vector_ack, // vector fetched
	output logic [15:0] fetched // last vector fetched
);
	logic [1:0] wait_cnt;
	// both masks set out of reset, so priority select writes are taken at once
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			global_mask <= 1'b1;
			x_mask <= 1'b1;
		end else begin
			global_mask <= want_i;
			x_mask <= x_mask & want_x;
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_n || !ack_en || !int_request) begin
			wait_cnt <= 2'h0;
			vector_ack <= 1'b0;
		end else begin
			wait_cnt <= wait_cnt + 2'h1;
			vector_ack <= (wait_cnt == 2'h3);
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			fetched <= 16'h0000;
		end else if (ack_en && int_request && wait_cnt == 2'h3) begin
			fetched <= vector_addr;
		end
	end
endmodule

// [dv/test_reset_interrupt_priority_resolver.sv]
// Purpose: self-checking bench for the reset and interrupt priority resolver
// Assumes: answers lag one edge, pin filters add a few more
// Notes: six idle cycles before each look cover the pin filters
`timescale 1ns/1ps
`include "rip_defs.svh"
module test_reset_interrupt_priority_resolver import rip_pkg::*;;
	logic clock, rst_n;
	logic [15:0] s_axi_awaddr, s_axi_araddr, vector_addr, fetched;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, maskable_index, ssrc, sen;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq_pin_n, x_mask;
	logic nonmaskable_pin_interrupt_n, global_mask, por_req, clock_fail, clock_monitor_enable;
	logic watchdog_timeout, watchdog_disable, illegal_opcode, software_trap, vector_ack;
	logic rx_full_set, rx_overrun, tx_empty, tx_done, idle_line, receive_irq_enable;
	logic transmit_empty_irq_enable, transmit_done_irq_enable, idle_line_irq_enable;
	logic serial_status_read, serial_data_read, int_read_strobe, int_request;
	logic receive_full_flag, ext_data_oe_n, want_i, want_x, ack_en, mode_pin_b, mode_pin_a;
	logic [12:0] periph_flag, periph_enable;
	logic [7:0] int_read_data, ext_data_out;
	logic [2:0] spulse;
	rip_src_e int_source;
	int fail_count = 0;
	int checks = 0;
	assign {idle_line, tx_done, tx_empty, rx_overrun} = ssrc;
	assign {idle_line_irq_enable, transmit_done_irq_enable, transmit_empty_irq_enable,
		receive_irq_enable} = sen;
	assign {rx_full_set, serial_status_read, serial_data_read} = spulse;
	rip_resolver #(.ADDR_W(16)) dut (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .mode_pin_b, .mode_pin_a,
		.irq_pin_n, .nonmaskable_pin_interrupt_n, .global_mask, .x_mask, .por_req, .clock_fail,
		.clock_monitor_enable, .watchdog_timeout, .watchdog_disable, .illegal_opcode,
		.software_trap, .vector_ack, .periph_flag, .periph_enable, .rx_full_set, .rx_overrun,
		.tx_empty, .tx_done, .idle_line, .receive_irq_enable, .transmit_empty_irq_enable,
		.transmit_done_irq_enable, .idle_line_irq_enable, .serial_status_read, .serial_data_read,
		.int_read_strobe, .int_read_data, .int_request, .vector_addr, .int_source,
		.maskable_index, .receive_full_flag, .ext_data_out, .ext_data_oe_n);
	rip_cpu_model cpu (.clock, .rst_n, .int_request, .vector_addr, .want_i, .want_x, .ack_en,
		.global_mask, .x_mask, .vector_ack, .fetched);
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		// ready is combinational on held inputs, so the low phase shows the edge value
		while (!(aw_ok && w_ok)) begin
			@(negedge clock);
			aw_ok = aw_ok || s_axi_awready;
			w_ok = w_ok || s_axi_wready;
			@(posedge clock);
			if (aw_ok) s_axi_awvalid <= 1'b0;
			if (w_ok) s_axi_wvalid <= 1'b0;
		end
		do @(negedge clock); while (s_axi_bvalid !== 1'b1);
		chk(s_axi_bresp, `RIP_RESP_OKAY);
		@(posedge clock);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic [1:0] resp);
		@(posedge clock);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(negedge clock); while (s_axi_arready !== 1'b1);
		@(posedge clock);
		s_axi_arvalid <= 1'b0;
		do @(negedge clock); while (s_axi_rvalid !== 1'b1);
		chk(s_axi_rdata, {24'h000000, exp});
		chk(s_axi_rresp, resp);
		@(posedge clock);
		s_axi_rready <= 1'b0;
	endtask
	task automatic win(input rip_src_e s, input logic [15:0] v, input logic [3:0] idx);
		repeat (6) @(posedge clock);
		@(negedge clock);
		chk(int_request, 1'b1);
		chk(int_source, s);
		chk(vector_addr, v);
		if (s === RIP_SRC_MASKABLE) chk(maskable_index, idx);
	endtask
	task automatic none();
		repeat (6) @(posedge clock);
		@(negedge clock);
		chk(int_request, 1'b0);
	endtask
	task automatic blip(input logic [2:0] p);
		@(posedge clock);
		spulse <= p;
		@(posedge clock);
		spulse <= 3'h0;
	endtask
	task automatic boot(input logic [1:0] mode);
		rst_n <= 1'b0;
		{mode_pin_b, mode_pin_a} <= mode;
		// both masks set and no fetching, as a core leaves reset
		{want_i, want_x, ack_en, ssrc, sen, int_read_strobe, int_read_data} <= 20'hc0000;
		{por_req, clock_fail, clock_monitor_enable, watchdog_timeout, watchdog_disable} <= 5'h0;
		{illegal_opcode, software_trap, irq_pin_n, nonmaskable_pin_interrupt_n} <= 4'h3;
		{periph_flag, periph_enable} <= 26'h0;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		repeat (10) @(posedge clock);
	endtask
	task automatic t_modes();
		logic [7:0] tbl [4] = '{8'hc5, 8'h75, 8'h05, 8'h35};
		for (int m = 0; m < 4; m++) begin
			boot(m[1:0]);
			rd(`RIP_ADDR_HIGHEST_PRIORITY_AND_MODE, tbl[m], `RIP_RESP_OKAY);
		end
		rd(`RIP_ADDR_CTRL, 8'h00, `RIP_RESP_OKAY);
		rd(16'h1050, 8'h00, `RIP_RESP_SLVERR);
	endtask
	task automatic t_bits();
		boot(2'h2);
		wr(`RIP_ADDR_HIGHEST_PRIORITY_AND_MODE, 8'he5);
		rd(`RIP_ADDR_HIGHEST_PRIORITY_AND_MODE, 8'h05, `RIP_RESP_OKAY);
		boot(2'h1);
		wr(`RIP_ADDR_HIGHEST_PRIORITY_AND_MODE, 8'hc5);
		rd(`RIP_ADDR_HIGHEST_PRIORITY_AND_MODE, 8'hc5, `RIP_RESP_OKAY);
		wr(`RIP_ADDR_HIGHEST_PRIORITY_AND_MODE, 8'h15);
		rd(`RIP_ADDR_HIGHEST_PRIORITY_AND_MODE, 8'h15, `RIP_RESP_OKAY);
		wr(`RIP_ADDR_HIGHEST_PRIORITY_AND_MODE, 8'hf5);
		rd(`RIP_ADDR_HIGHEST_PRIORITY_AND_MODE, 8'h15, `RIP_RESP_OKAY);
	endtask
	task automatic peek(input logic oe_n);
		@(posedge clock);
		{int_read_strobe, int_read_data} <= 9'h1a7;
		@(posedge clock);
		int_read_strobe <= 1'b0;
		@(negedge clock);
		chk(ext_data_oe_n, oe_n);
		if (!oe_n) chk(ext_data_out, 8'ha7);
		@(negedge clock);
		chk(ext_data_oe_n, 1'b1);
	endtask
	task automatic t_vis();
		boot(2'h3);
		peek(1'b0);
		wr(`RIP_ADDR_HIGHEST_PRIORITY_AND_MODE, 8'h25);
		wr(`RIP_ADDR_HIGHEST_PRIORITY_AND_MODE, 8'h35);
		rd(`RIP_ADDR_HIGHEST_PRIORITY_AND_MODE, 8'h25, `RIP_RESP_OKAY);
		peek(1'b1);
	endtask
	task automatic t_nmi();
		boot(2'h2);
		{nonmaskable_pin_interrupt_n, software_trap, clock_fail, watchdog_timeout} <= 4'h7;
		{watchdog_disable, periph_flag[0], periph_enable[0]} <= 3'h7;
		win(RIP_SRC_SWTRAP, 16'hfff6, 4'h0);
		illegal_opcode <= 1'b1;
		win(RIP_SRC_ILLEGAL, 16'hfff8, 4'h0);
		want_x <= 1'b0;
		win(RIP_SRC_XPIN, 16'hfff4, 4'h0);
		watchdog_disable <= 1'b0;
		win(RIP_SRC_WATCHDOG, 16'hfffa, 4'h0);
		clock_monitor_enable <= 1'b1;
		win(RIP_SRC_CLKMON, 16'hfffc, 4'h0);
		por_req <= 1'b1;
		win(RIP_SRC_RESET, 16'hfffe, 4'h0);
	endtask
	task automatic t_order();
		boot(2'h2);
		{want_i, periph_enable, ssrc, sen} <= 22'h1fff22;
		for (int r = 14; r >= 0; r--) begin
			if (r == 0) irq_pin_n <= 1'b0;
			else if (r < 14) periph_flag[r-1] <= 1'b1;
			win(RIP_SRC_MASKABLE, 16'hfff2 - 16'(2 * r), 4'(r));
		end
		ack_en <= 1'b1;
		win(RIP_SRC_MASKABLE, 16'hfff2, 4'h0);
		chk(fetched, 16'hfff2);
		want_i <= 1'b1;
		none();
		{irq_pin_n, periph_flag, ssrc, want_i} <= 19'h40000;
		none();
		// edge mode: a fetch consumes the latched edge although the pin stays low
		ack_en <= 1'b0;
		wr(`RIP_ADDR_CTRL, 8'h01);
		rd(`RIP_ADDR_CTRL, 8'h01, `RIP_RESP_OKAY);
		irq_pin_n <= 1'b0;
		win(RIP_SRC_MASKABLE, 16'hfff2, 4'h0);
		ack_en <= 1'b1;
		repeat (2) @(posedge clock);
		none();
		chk(fetched, 16'hfff2);
	endtask
	task automatic t_prom();
		logic [3:0] rank [16] = '{4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'h0, 4'h0, 4'h1,
			4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
		boot(2'h2);
		{periph_flag, periph_enable, ssrc, sen, irq_pin_n} <= 35'h7fffffe44;
		for (int c = 0; c < 16; c++) begin
			want_i <= 1'b1;
			repeat (2) @(posedge clock);
			wr(`RIP_ADDR_HIGHEST_PRIORITY_AND_MODE, {4'h0, 4'(c)});
			want_i <= 1'b0;
			win(RIP_SRC_MASKABLE, 16'hfff2 - {11'h0, rank[c], 1'b0}, rank[c]);
		end
		wr(`RIP_ADDR_HIGHEST_PRIORITY_AND_MODE, 8'h00);
		rd(`RIP_ADDR_HIGHEST_PRIORITY_AND_MODE, 8'h0f, `RIP_RESP_OKAY);
		periph_enable[8] <= 1'b0;
		win(RIP_SRC_MASKABLE, 16'hfff2, 4'h0);
		want_i <= 1'b1;
		none();
	endtask
	task automatic t_serial();
		boot(2'h2);
		want_i <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			ssrc <= 4'h1 << i;
			sen <= ~(4'h1 << i);
			none();
			sen <= 4'hf;
			win(RIP_SRC_MASKABLE, 16'hffd6, 4'he);
		end
		{ssrc, sen} <= 8'h01;
		blip(3'h4);
		win(RIP_SRC_MASKABLE, 16'hffd6, 4'he);
		blip(3'h1);
		win(RIP_SRC_MASKABLE, 16'hffd6, 4'he);
		chk(receive_full_flag, 1'b1);
		blip(3'h2);
		blip(3'h1);
		none();
		chk(receive_full_flag, 1'b0);
		sen <= 4'h0;
		blip(3'h4);
		none();
		chk(receive_full_flag, 1'b1);
	endtask
	task automatic summarize();
		if (fail_count == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, spulse} <= 71'h78;
		boot(2'h2);
		t_modes();
		t_bits();
		t_vis();
		t_nmi();
		t_order();
		t_prom();
		t_serial();
		summarize();
	end
	// whole sequence needs under a thousand cycles
	initial begin
		repeat (20000) @(posedge clock);
		fail_count++;
		summarize();
	end
endmodule
